/* File: hdl/line_seq_defines.vh */
// constants for the line bypass contactor sequencer
// assumes a 25 MHz control clock and a 32-bit classic wishbone register port
`ifndef LINE_SEQ_DEFINES_VH
`define LINE_SEQ_DEFINES_VH

// clock and timing base
`define CLK_HZ            25000000
`define TICK_MS           10
`define BASE_DELAY_MS     200
`define BASE_TICKS        (`BASE_DELAY_MS / `TICK_MS)

// register byte offsets
`define ADDR_IN_MAP       8'h00
`define ADDR_OUT_MAP      8'h04
`define ADDR_RUN_MAP      8'h08
`define ADDR_CFG          8'h0C
`define ADDR_STATUS       8'h10

// input terminal function codes
`define FC_SW_50HZ        8'h28
`define FC_SW_60HZ        8'h29
`define FC_RUN_FWD        8'h62
`define FC_RUN_REV        8'h63

// output terminal function codes
`define FC_LINE_MC        8'h0B
`define FC_OUT_MC         8'h0C
`define FC_IN_MC          8'h0D
`define FC_NONE           8'hFF

// reset values
`define RST_IN_MAP        32'hFFFFFFFF
`define RST_OUT_MAP       32'h00FFFFFF
`define RST_RUN_MAP       32'h00006362
`define RST_CFG           32'h00000000

// configuration field positions
`define CFG_WAIT_MSB      15
`define CFG_POLICY_BIT    16

`endif

/* File: hdl/seq_delay_timer.v */
// one-shot delay timer counting 10 ms ticks from a divided clock enable
// assumes start is a one-cycle pulse; a new start restarts the delay cleanly
`timescale 1ns/1ps
module seq_delay_timer #(
  parameter TICK_CYC = 250000,
  parameter CNT_W    = 17
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst_n,
  // control
  input  wire             start,
  input  wire [CNT_W-1:0] ticks,
  // status
  output reg              done
);

  reg [31:0]      div_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg             busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // divider is cleared on start so the first tick is a full 10 ms away
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg  <= 32'h00000000;
      cnt_reg  <= {CNT_W{1'b0}};
      busy_reg <= 1'b0;
      done     <= 1'b0;
    end else if (start) begin
      div_reg  <= 32'h00000000;
      cnt_reg  <= ticks;
      busy_reg <= 1'b1;
      done     <= 1'b0;
    end else if (busy_reg) begin
      if (div_reg == TICK_CYC - 1) begin
        div_reg <= 32'h00000000;
        if (cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end else begin
        div_reg <= div_reg + 32'h00000001;
      end
    end
  end

endmodule

/* File: hdl/line_bypass_contactor_sequencer.v */
// switches the motor between mains line and inverter output by contactor sequence
// assumes synchronous terminal inputs and a classic wishbone master on ref_clk
//
// Overview of operation
// - sequence runs only with a switch input plus line and output contactor outputs mapped
// - input code 40 selects 50 Hz switch, 41 selects 60 Hz restart frequency
// - switch command falling shuts the power stage off at once
// - switch command falling drops input and output contactor controls at once
// - after 0.2 s plus restart wait, line contactor closes only if run present
// - switch command rising closes the input contactor at once
// - switch command rising opens the line contactor at once
// - output contactor closes 0.2 s plus main-circuit ready after input contactor
// - 0.2 s plus restart wait later, pick up coasting motor at line frequency
// - alarm policy 0 stops on alarm, 1 forces a switch to line
// - sequence works with the input contactor unmapped and mains always present
// - code 98 is forward run; release decelerates to stop
// - code 99 is reverse run; release decelerates to stop
// - run commands come only from the two run-terminal settings
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ps
`include "line_seq_defines.vh"
module line_bypass_contactor_sequencer #(
  parameter N_IN     = 4,
  parameter N_OUT    = 3,
  parameter TICK_CYC = `CLK_HZ / 1000 * `TICK_MS
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst_n,
  // classic wishbone slave
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [7:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  // terminals and drive status
  input  wire [N_IN-1:0]  x_in,
  input  wire             run_term_a,
  input  wire             run_term_b,
  input  wire             alarm_in,
  input  wire             main_ready,
  // contactor output terminals
  output reg  [N_OUT-1:0] y_out,
  // drive control
  output reg              power_stage_en,
  output reg              run_forward_cmd,
  output reg              run_reverse_cmd,
  output reg              pickup_start,
  output reg              line_freq_60hz
);

  localparam ST_LINE  = 3'h0;
  localparam ST_LWAIT = 3'h1;
  localparam ST_READY = 3'h2;
  localparam ST_CONN  = 3'h3;
  localparam ST_INV   = 3'h4;

  // software registers
  reg [31:0] in_map_reg;
  reg [31:0] out_map_reg;
  reg [31:0] run_map_reg;
  reg [31:0] cfg_reg;
  // sequencer state
  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg        sw_prev_reg;
  reg        line_mc_reg;
  reg        in_mc_reg;
  reg        out_mc_reg;
  reg        line_mc_next;
  reg        in_mc_next;
  reg        out_mc_next;
  reg        tmr_start;
  reg [16:0] tmr_ticks;
  reg        pickup_next;
  wire       tmr_done;

  ////////////////////////////////////////////////////////////////////////////
  // terminal decoding

  wire [N_IN-1:0]  is_sw50;
  wire [N_IN-1:0]  is_sw60;
  wire [N_OUT-1:0] is_line;
  wire [N_OUT-1:0] is_out;
  wire [N_OUT-1:0] y_next;

  genvar gi;
  // per input terminal: only the switch codes matter here, run codes are ignored
  generate
    for (gi = 0; gi < N_IN; gi = gi + 1) begin : g_in
      assign is_sw50[gi] = (in_map_reg[gi*8 +: 8] == `FC_SW_50HZ);
      assign is_sw60[gi] = (in_map_reg[gi*8 +: 8] == `FC_SW_60HZ);
    end
  endgenerate

  // per output terminal: route the matching contactor control
  generate
    for (gi = 0; gi < N_OUT; gi = gi + 1) begin : g_out
      assign is_line[gi] = (out_map_reg[gi*8 +: 8] == `FC_LINE_MC);
      assign is_out[gi]  = (out_map_reg[gi*8 +: 8] == `FC_OUT_MC);
      assign y_next[gi]  = (is_line[gi] & line_mc_reg) | (is_out[gi] & out_mc_reg) |
                           ((out_map_reg[gi*8 +: 8] == `FC_IN_MC) & in_mc_reg);
    end
  endgenerate

  // sequence enable needs a switch input and both line and output contactors
  wire sw_mapped = |(is_sw50 | is_sw60);
  wire seq_en    = sw_mapped & (|is_line) & (|is_out);
  // both codes mapped is undefined; the OR simply treats either as the switch
  wire sw_raw    = |((is_sw50 | is_sw60) & x_in);
  wire policy    = cfg_reg[`CFG_POLICY_BIT];
  // policy 1 turns an alarm into a forced switch to line operation
  wire sw_eff    = seq_en & sw_raw & ~(alarm_in & policy);
  wire sw_rise   = sw_eff & ~sw_prev_reg;
  wire sw_fall   = ~sw_eff & sw_prev_reg;

  // run commands come only from the two dedicated run terminals
  wire fwd_raw = ((run_map_reg[7:0] == `FC_RUN_FWD) & run_term_a) |
                 ((run_map_reg[15:8] == `FC_RUN_FWD) & run_term_b);
  wire rev_raw = ((run_map_reg[7:0] == `FC_RUN_REV) & run_term_a) |
                 ((run_map_reg[15:8] == `FC_RUN_REV) & run_term_b);
  // both directions at once is taken as no run, so the motor decelerates
  wire fwd_ok  = fwd_raw & ~rev_raw;
  wire rev_ok  = rev_raw & ~fwd_raw;
  wire run_any = fwd_ok | rev_ok;

  // timing counts are 32-bit integers in the header; keep only the timer width
  wire [31:0] base_full  = `BASE_TICKS;
  wire [16:0] base_ticks = base_full[16:0];
  wire [16:0] t1_ticks   = base_ticks + {1'b0, cfg_reg[`CFG_WAIT_MSB:0]};

  ////////////////////////////////////////////////////////////////////////////
  // delay timer shared by t1, t2 and t3; only one is ever pending

  seq_delay_timer #(
    .TICK_CYC (TICK_CYC),
    .CNT_W    (17)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (tmr_start),
    .ticks   (tmr_ticks),
    .done    (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer next state

  always @* begin
    state_next   = state_reg;
    line_mc_next = line_mc_reg;
    in_mc_next   = in_mc_reg;
    out_mc_next  = out_mc_reg;
    tmr_start    = 1'b0;
    tmr_ticks    = t1_ticks;
    pickup_next  = 1'b0;
    if (!seq_en) begin
      // plain inverter drive: no contactors handled
      state_next   = ST_LINE;
      line_mc_next = 1'b0;
      in_mc_next   = 1'b0;
      out_mc_next  = 1'b0;
    end else if (sw_fall && state_reg != ST_LINE && state_reg != ST_LWAIT) begin
      // inverter side drops at once, line waits for t1
      in_mc_next   = 1'b0;
      out_mc_next  = 1'b0;
      tmr_start    = 1'b1;
      tmr_ticks    = t1_ticks;
      state_next   = ST_LWAIT;
    end else if (sw_rise && (state_reg == ST_LINE || state_reg == ST_LWAIT)) begin
      in_mc_next   = 1'b1;
      line_mc_next = 1'b0;
      tmr_start    = 1'b1;
      tmr_ticks    = base_ticks;
      state_next   = ST_READY;
    end else begin
      case (state_reg)
        ST_LINE: begin
          line_mc_next = run_any;
          in_mc_next   = 1'b0;
          out_mc_next  = 1'b0;
        end
        ST_LWAIT: begin
          // line closes only if a run command is there when t1 ends
          if (tmr_done) begin
            line_mc_next = run_any;
            state_next   = ST_LINE;
          end
        end
        ST_READY: begin
          // t2 ends once the 0.2 s base has run out and the main circuit is ready
          if (tmr_done && main_ready) begin
            out_mc_next = 1'b1;
            tmr_start   = 1'b1;
            tmr_ticks   = t1_ticks;
            state_next  = ST_CONN;
          end
        end
        ST_CONN: begin
          if (tmr_done) begin
            pickup_next = 1'b1;
            state_next  = ST_INV;
          end
        end
        ST_INV: begin
          line_mc_next = 1'b0;
          in_mc_next   = 1'b1;
          out_mc_next  = 1'b1;
        end
        default: begin
          state_next   = ST_LINE;
          line_mc_next = 1'b0;
          in_mc_next   = 1'b0;
          out_mc_next  = 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer registers and drive outputs

  // power stage is gated by the current state and by sw_fall, so a falling switch kills it
  // in the same cycle the state leaves inverter operation
  wire inv_drive = ~seq_en | (state_reg == ST_INV);

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg       <= ST_LINE;
      sw_prev_reg     <= 1'b0;
      line_mc_reg     <= 1'b0;
      in_mc_reg       <= 1'b0;
      out_mc_reg      <= 1'b0;
      y_out           <= {N_OUT{1'b0}};
      power_stage_en  <= 1'b0;
      run_forward_cmd <= 1'b0;
      run_reverse_cmd <= 1'b0;
      pickup_start    <= 1'b0;
      line_freq_60hz  <= 1'b0;
    end else begin
      state_reg       <= state_next;
      sw_prev_reg     <= sw_eff;
      line_mc_reg     <= line_mc_next;
      in_mc_reg       <= in_mc_next;
      out_mc_reg      <= out_mc_next;
      y_out           <= y_next;
      // policy 0 keeps inverter operation but stops on alarm
      power_stage_en  <= inv_drive & ~sw_fall & run_any & ~alarm_in;
      run_forward_cmd <= inv_drive & ~sw_fall & fwd_ok & ~alarm_in;
      run_reverse_cmd <= inv_drive & ~sw_fall & rev_ok & ~alarm_in;
      pickup_start    <= pickup_next;
      if (sw_rise) begin
        line_freq_60hz <= ~(|(is_sw50 & x_in));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, unmapped reads zero, writes dropped

  wire wr_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i;

  // merge enabled byte lanes into a register value
  function [31:0] merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    integer      b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge[b*8 +: 8] = dat[b*8 +: 8];
        end
      end
    end
  endfunction

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_map_reg  <= `RST_IN_MAP;
      out_map_reg <= `RST_OUT_MAP;
      run_map_reg <= `RST_RUN_MAP;
      cfg_reg     <= `RST_CFG;
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h00000000;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
        case (wb_adr_i)
          `ADDR_IN_MAP:  wb_dat_o <= in_map_reg;
          `ADDR_OUT_MAP: wb_dat_o <= {8'h00, out_map_reg[23:0]};
          `ADDR_RUN_MAP: wb_dat_o <= {16'h0000, run_map_reg[15:0]};
          `ADDR_CFG:     wb_dat_o <= {15'h0000, cfg_reg[16:0]};
          `ADDR_STATUS:  wb_dat_o <= {20'h00000, line_freq_60hz, seq_en, power_stage_en,
                                      out_mc_reg, in_mc_reg, line_mc_reg, 3'h0, state_reg};
          default:       wb_dat_o <= 32'h00000000;
        endcase
      end
      if (wr_hit) begin
        case (wb_adr_i)
          `ADDR_IN_MAP:  in_map_reg  <= merge(in_map_reg, wb_dat_i, wb_sel_i);
          `ADDR_OUT_MAP: out_map_reg <= merge(out_map_reg, wb_dat_i, wb_sel_i);
          `ADDR_RUN_MAP: run_map_reg <= merge(run_map_reg, wb_dat_i, wb_sel_i);
          `ADDR_CFG:     cfg_reg     <= merge(cfg_reg, wb_dat_i, wb_sel_i);
          default:       cfg_reg     <= cfg_reg;
        endcase
      end
    end
  end

endmodule

/* File: tb/line_seq_sva.sv */
// port checker for the line bypass contactor sequencer
// assumes y_out[0] line, [1] output, [2] input contactor; x_in[0]/[1] switch inputs
`timescale 1ns/1ps
module line_seq_sva #(
  parameter N_IN  = 4,
  parameter N_OUT = 3
) (
  // clock and reset
  input logic             ref_clk,
  input logic             rst_n,
  // register bus
  input logic             wb_cyc_i,
  input logic             wb_stb_i,
  input logic [31:0]      wb_dat_o,
  input logic             wb_ack_o,
  // terminals and drive
  input logic [N_IN-1:0]  x_in,
  input logic             alarm_in,
  input logic [N_OUT-1:0] y_out,
  input logic             power_stage_en,
  input logic             run_forward_cmd,
  input logic             run_reverse_cmd,
  input logic             pickup_start
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // bus handshake
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  ////////////////////////////////////////////////////////////////////////
  // drive and contactor relations
  property p_no_both_run; !(run_forward_cmd && run_reverse_cmd); endproperty
  a_no_both_run: assert property (p_no_both_run) else $error("both run outputs");
  property p_pick_pulse; pickup_start |=> !pickup_start; endproperty
  a_pick_pulse: assert property (p_pick_pulse) else $error("pickup not a pulse");
  property p_pick_state; pickup_start |-> y_out[1] && !y_out[0]; endproperty
  a_pick_state: assert property (p_pick_state) else $error("pickup off inverter");
  property p_interlock; !(y_out[0] && (y_out[1] || y_out[2])); endproperty
  a_interlock: assert property (p_interlock) else $error("line with inverter mc");
  property p_power_mc; power_stage_en |-> y_out[1]; endproperty
  a_power_mc: assert property (p_power_mc) else $error("power without output mc");
  property p_sw_rise; $rose(x_in[0]) && !x_in[1] && !alarm_in |-> ##2 y_out[2] && !y_out[0];
  endproperty
  a_sw_rise: assert property (p_sw_rise) else $error("switch rise response");
  property p_sw_fall;
    $fell(x_in[0]) && !x_in[1] |=> !power_stage_en ##1 !y_out[1] && !y_out[2];
  endproperty
  a_sw_fall: assert property (p_sw_fall) else $error("switch fall response");
endmodule
bind line_bypass_contactor_sequencer line_seq_sva #(.N_IN(N_IN), .N_OUT(N_OUT)) line_seq_sva_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .x_in(x_in), .alarm_in(alarm_in),
  .y_out(y_out), .power_stage_en(power_stage_en), .run_forward_cmd(run_forward_cmd),
  .run_reverse_cmd(run_reverse_cmd), .pickup_start(pickup_start));

/* File: tb/contactor_model.sv */
// external contactors and main circuit seen by the sequencer
// assumes y_out[0] line, [1] output, [2] input contactor coil
`timescale 1ns/1ps
module contactor_model #(
  parameter READY_CYC = 10
) (
  // clock and reset
  input  logic       ref_clk,
  input  logic       rst_n,
  // coil drives
  input  logic [2:0] y_out,
  // status back
  output logic       main_ready,
  output logic       motor_on_line
);
  int cnt;
  // main circuit charges only while the input contactor is held
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n || !y_out[2]) begin
      cnt <= 0;
      main_ready <= 1'b0;
    end else if (cnt < READY_CYC) begin
      cnt <= cnt + 1;
    end else begin
      main_ready <= 1'b1;
    end
  end
  // outside interlock: line coil blocked while output contactor held
  assign motor_on_line = y_out[0] & ~y_out[1];
endmodule

/* File: tb/tb_line_bypass_contactor_sequencer.sv */
// self-checking bench for the line bypass contactor sequencer
// assumes TICK_CYC cut to 4 clocks, restart wait 2 ticks, so each delay is about 80-88 clocks
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
  num_checks++; \
  if ((got) !== (ex)) begin \
    fail_count++; \
    $display("unexpected %s exp %0h got %0h", nm, ex, got); \
  end \
end
module tb_line_bypass_contactor_sequencer;
  // bench signals
  logic        ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, x_in;
  logic [31:0] wb_dat_i, wb_dat_o, rnd, ex_v;
  logic        run_term_a, run_term_b, alarm_in, main_ready, motor_on_line;
  logic [2:0]  y_out;
  logic        power_stage_en, run_forward_cmd, run_reverse_cmd, pickup_start, line_freq_60hz;
  logic [31:0] exp_q[$];
  int          fail_count, num_checks, n, seed;
  line_bypass_contactor_sequencer #(.TICK_CYC(4)) line_bypass_contactor_sequencer_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .x_in(x_in), .run_term_a(run_term_a),
    .run_term_b(run_term_b), .alarm_in(alarm_in), .main_ready(main_ready), .y_out(y_out),
    .power_stage_en(power_stage_en), .run_forward_cmd(run_forward_cmd),
    .run_reverse_cmd(run_reverse_cmd), .pickup_start(pickup_start),
    .line_freq_60hz(line_freq_60hz));
  contactor_model contactor_model_i (.ref_clk(ref_clk), .rst_n(rst_n), .y_out(y_out),
    .main_ready(main_ready), .motor_on_line(motor_on_line));
  ////////////////////////////////////////////////////////////////////////
  // clock and watchdog; a hang counts as a mismatch
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    print_verdict();
  end
  // read data monitor takes the oldest note at each read ack
  always @(negedge ref_clk) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      ex_v = exp_q.pop_front();
      `CHK("rdata", ex_v, wb_dat_o)
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // request held until ack seen high at a rising edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge ref_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
    // only the watchdog ends a wait that never sees ack
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 4'hF, 32'h0);
  endtask
  task automatic drv(input logic [3:0] x, input logic a, input logic b, input logic al);
    @(posedge ref_clk);
    {x_in, run_term_a, run_term_b, alarm_in} <= {x, a, b, al};
  endtask
  // bounded wait for a contactor coil, or pickup when b is 3
  task automatic wait_hi(input int b, output int c);
    c = 0;
    while (((b == 3) ? pickup_start : y_out[b]) !== 1'b1 && c < 400) begin
      @(negedge ref_clk);
      c++;
    end
  endtask
  task automatic go_inv(input logic [3:0] x, input logic e60);
    drv(x, 1'b1, 1'b0, 1'b0);
    repeat (3) @(negedge ref_clk);
    `CHK("y_rise", 3'h4, y_out)
    wait_hi(1, n);
    `CHK("t2", 1'b1, n >= 76 && n <= 84)
    wait_hi(3, n);
    `CHK("t3", 1'b1, n >= 84 && n <= 92)
    repeat (3) @(negedge ref_clk);
    `CHK("power", 1'b1, power_stage_en)
    `CHK("fwd", 1'b1, run_forward_cmd)
    `CHK("freq", e60, line_freq_60hz)
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'h94a71c1f;
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, run_term_a, run_term_b, alarm_in} = 7'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i, x_in} = 48'h0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'hFFFFFFFF);
    rd(8'h04, 32'h00FFFFFF);
    rd(8'h08, 32'h00006362);
    wb(1'b1, 8'h20, 4'hF, 32'h12345678);
    rd(8'h20, 32'h0);
    rnd = $random(seed);
    wb(1'b1, 8'h0C, 4'hF, rnd);
    rd(8'h0C, rnd & 32'h0001FFFF);
    // only one switch code is ever mapped at a time
    wb(1'b1, 8'h00, 4'h1, 32'h28);
    rd(8'h00, 32'hFFFFFF28);
    wb(1'b1, 8'h04, 4'hF, 32'h000D0C0B);
    wb(1'b1, 8'h0C, 4'hF, 32'h2);
    $display("done registers");
    // line operation: line coil follows run
    drv(4'h0, 1'b1, 1'b0, 1'b0);
    repeat (3) @(negedge ref_clk);
    `CHK("y_line", 3'h1, y_out)
    `CHK("power_line", 1'b0, power_stage_en)
    drv(4'h0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(negedge ref_clk);
    `CHK("y_idle", 3'h0, y_out)
    $display("done line");
    go_inv(4'h1, 1'b0);
    rd(8'h10, 32'h00000784);
    drv(4'h1, 1'b0, 1'b1, 1'b0);
    repeat (3) @(negedge ref_clk);
    `CHK("rev", 2'b01, {run_forward_cmd, run_reverse_cmd})
    drv(4'h1, 1'b0, 1'b1, 1'b1);
    repeat (3) @(negedge ref_clk);
    `CHK("alarm0", 4'h6, {power_stage_en, y_out})
    drv(4'h0, 1'b0, 1'b1, 1'b0);
    wait_hi(0, n);
    `CHK("t1", 1'b1, n >= 84 && n <= 94)
    $display("done inverter to line");
    // run absent when the wait ends: line coil stays open
    go_inv(4'h1, 1'b0);
    drv(4'h0, 1'b0, 1'b0, 1'b0);
    repeat (110) @(negedge ref_clk);
    `CHK("y_norun", 3'h0, y_out)
    $display("done no run");
    // policy 1: alarm forces the line
    wb(1'b1, 8'h0C, 4'hF, 32'h00010002);
    // swap to the 60 Hz switch on x_in[1] in one write, 50 Hz code removed
    wb(1'b1, 8'h00, 4'h3, 32'h000029FF);
    rd(8'h00, 32'hFFFF29FF);
    go_inv(4'h2, 1'b1);
    drv(4'h2, 1'b1, 1'b0, 1'b1);
    repeat (3) @(negedge ref_clk);
    `CHK("power_alarm", 1'b0, power_stage_en)
    wait_hi(0, n);
    `CHK("y_alarm", 3'h1, y_out)
    $display("done alarm policy");
    print_verdict();
  end
endmodule
